// ### pkg/ndai_pkg.sv
// Constants for the host-side controller of a 1M x 1 strobe-driven dynamic RAM.
// Assumes a single 20 MHz clock; all times but column access, address access and read hold are converted to cycles here.
package ndai_pkg;

    localparam int unsigned CLK_PERIOD_NS        = 50;
    localparam int unsigned ROW_BITS             = 10;
    localparam int unsigned COL_BITS             = 10;
    localparam int unsigned ADDR_BITS            = 20;
    localparam int unsigned CELL_COUNT           = 1048576;
    // Fastest-grade times in ns, as printed.
    localparam int unsigned ROW_ACCESS_NS        = 70;
    localparam int unsigned COL_ACCESS_NS        = 20;
    localparam int unsigned ADDR_ACCESS_NS       = 35;
    localparam int unsigned RANDOM_CYCLE_TIME_NS = 140;
    localparam int unsigned ROW_PRECHARGE_NS     = 60;
    localparam int unsigned REFRESH_COLUMN_PRECHARGE_TIME_NS = 20;
    localparam int unsigned WRITE_TO_ROW_STROBE_LEAD_NS      = 15;
    localparam int unsigned READ_HOLD_TO_ROW_STROBE_NS       = 0;
    localparam int unsigned REFRESH_ROWS         = 512;
    localparam int unsigned REFRESH_PERIOD_US    = 8200;
    localparam int unsigned POWERUP_PAUSE_US     = 200;
    localparam int unsigned INIT_CYCLES          = 8;

    function automatic int unsigned ns_up(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Cycle counts: least times round up, longest times round down.
    localparam int unsigned ROW_ACCESS_CYC  = ns_up(ROW_ACCESS_NS);
    localparam int unsigned RC_CYC          = ns_up(RANDOM_CYCLE_TIME_NS);
    localparam int unsigned RP_CYC          = ns_up(ROW_PRECHARGE_NS);
    localparam int unsigned CPN_CYC         = ns_up(REFRESH_COLUMN_PRECHARGE_TIME_NS);
    localparam int unsigned RWL_CYC         = ns_up(WRITE_TO_ROW_STROBE_LEAD_NS);
    localparam int unsigned REFRESH_INTERVAL_CYC =
        (REFRESH_PERIOD_US * 1000 / REFRESH_ROWS) / CLK_PERIOD_NS;
    localparam int unsigned POWERUP_CYC     = POWERUP_PAUSE_US * 1000 / CLK_PERIOD_NS;

    typedef enum logic [6:0] {
        NDAI_IDLE   = 7'h01,
        NDAI_ROW    = 7'h02,
        NDAI_COL    = 7'h04,
        NDAI_DATA   = 7'h08,
        NDAI_PRECH  = 7'h10,
        NDAI_CBR    = 7'h20,
        NDAI_PAUSE  = 7'h40
    } ndai_state_e;

endpackage

// ### rtl/ndai_timer.sv
// Down-counting interval timer that pulses when it expires and reloads.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ps
module ndai_timer #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             I_REF_CLK,
    input  wire logic             I_RST_B,
    input  wire logic [WIDTH-1:0] i_load,
    output logic                  o_expire
);
    logic [WIDTH-1:0] cnt_reg;
    logic [WIDTH-1:0] cnt_next;

    always_comb begin
        o_expire = (cnt_reg == '0);
        cnt_next = o_expire ? i_load : cnt_reg - {{(WIDTH-1){1'b0}}, 1'b1};
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule

// ### rtl/ndai_host.sv
// Host controller driving a 1M x 1 dynamic RAM through its strobes and muxed address.
// Assumes the RAM's data-out is sampled synchronously; strobes are active low on the pins.
`timescale 1ns/1ps
// How it works
// R1: Twenty-bit cell address split into two ten-bit halves on shared pins.
// R2: Row half presented first with row strobe fall, then column with column strobe.
// R3: Each address half is stable before and at its strobe's falling edge.
// R4: Device latches pass addresses through; we hold column until cycle end anyway.
// R5: Write strobe low selects write, high selects read; data ignored on reads.
// R6: Device captures data on the later of column or write strobe falls.
// R7: Early write: write strobe low before column strobe falls, data stable then.
// R8: Delayed write would capture on write strobe; we use early writes only.
// R9: Device output is high impedance until column strobe falls.
// R10: Read data sampled no earlier than row access time after row strobe fall.
// R11: Column access time is met because sampling waits past it.
// R12: Column address access time is met by the same wait.
// R13: One refresh every interval so 512 rows are covered each 8.2 ms.
// R14: Random cycles spaced at least the random cycle time apart.
// R15: Column strobe precharged high before a column-before-row refresh.
// R16: Write strobe held high on reads until both strobes rise.
// R17: Write strobe low at least the lead time before row strobe rises.
// R18: Power-up pause of 200 us with strobes high, then eight init cycles.
// R19: Row-only refresh keeps column strobe high; unused, we refresh by counter.
// R20: Column-before-row refresh uses the device's internal row counter.
module ndai_host
    import ndai_pkg::*;
(
    input  wire logic                 I_REF_CLK,
    input  wire logic                 I_RST_B,
    input  wire logic                 I_REQ_VALID,
    input  wire logic                 I_REQ_WRITE,
    input  wire logic [ADDR_BITS-1:0] I_REQ_ADDR,
    input  wire logic                 I_REQ_WDATA,
    output logic                      O_REQ_READY,
    output logic                      O_RDATA_VALID,
    output logic                      O_RDATA,
    output logic                      O_INIT_DONE,
    output logic                      O_ROW_STROBE_B,
    output logic                      O_COL_STROBE_B,
    output logic                      O_WRITE_STROBE_B,
    output logic [ROW_BITS-1:0]       O_MUXED_ADDRESS,
    output logic                      O_DATA_IN,
    input  wire logic                 I_DATA_OUT
);
    localparam int unsigned CW = 13;
    localparam logic [CW-1:0] POWERUP_C  = CW'(POWERUP_CYC);
    localparam logic [CW-1:0] ACCESS_C   = CW'(ROW_ACCESS_CYC);
    localparam logic [CW-1:0] PRECH_C    = CW'(RP_CYC);
    localparam logic [CW-1:0] CPN_C      = CW'(CPN_CYC);
    localparam logic [CW-1:0] RWL_C      = CW'(RWL_CYC);
    localparam logic [CW-1:0] RC_C       = CW'(RC_CYC);
    localparam logic [3:0]    INIT_C     = 4'(INIT_CYCLES);

    ndai_state_e state_reg, state_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [3:0] init_reg, init_next;
    logic ref_pend_reg, ref_pend_next;
    logic wr_reg, wr_next;
    logic [ADDR_BITS-1:0] addr_reg, addr_next;
    logic wd_reg, wd_next;
    logic ras_reg, ras_next, cas_reg, cas_next, we_reg, we_next;
    logic [ROW_BITS-1:0] ma_reg, ma_next;
    logic rv_reg, rv_next, rd_reg, rd_next;
    logic tick;

    // R13: refresh interval timer.
    ndai_timer #(.WIDTH(CW)) u_ref_timer (
        .I_REF_CLK (I_REF_CLK),
        .I_RST_B   (I_RST_B),
        .i_load    (CW'(REFRESH_INTERVAL_CYC - 1)),
        .o_expire  (tick)
    );

    assign O_INIT_DONE = (init_reg == INIT_C);
    assign O_REQ_READY = (state_reg == NDAI_IDLE) && O_INIT_DONE && !ref_pend_reg && !tick;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = (cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg;
        init_next     = init_reg;
        // R13: a pending refresh is set by the timer and wins over its clear.
        ref_pend_next = ref_pend_reg;
        wr_next       = wr_reg;
        addr_next     = addr_reg;
        wd_next       = wd_reg;
        ras_next      = ras_reg;
        cas_next      = cas_reg;
        we_next       = we_reg;
        ma_next       = ma_reg;
        rv_next       = 1'b0;
        rd_next       = rd_reg;
        case (state_reg)
            // R18: power-up pause with both strobes high.
            NDAI_PAUSE: begin
                if (cnt_reg == '0) begin
                    state_next = NDAI_IDLE;
                end
            end
            NDAI_IDLE: begin
                // R19: counter refresh only, no row-only cycle.
                if ((ref_pend_reg || !O_INIT_DONE) && cnt_reg == '0) begin
                    // R15: column strobe precharged before the refresh starts.
                    state_next = NDAI_CBR;
                    cas_next   = 1'b0;
                    cnt_next   = CPN_C;
                    ref_pend_next = 1'b0;
                end else if (I_REQ_VALID && O_REQ_READY) begin
                    // R1: split the address; R3: row half set up before its strobe.
                    wr_next   = I_REQ_WRITE;
                    addr_next = I_REQ_ADDR;
                    wd_next   = I_REQ_WDATA;
                    ma_next   = I_REQ_ADDR[ADDR_BITS-1:COL_BITS];
                    state_next = NDAI_ROW;
                end
            end
            NDAI_ROW: begin
                // R2: row strobe falls on a stable row half.
                ras_next   = 1'b0;
                state_next = NDAI_COL;
                cnt_next   = RC_C;
            end
            NDAI_COL: begin
                // R2: column half presented; R7: write strobe low before column strobe.
                ma_next    = addr_reg[COL_BITS-1:0];
                // R8: early write only, never delayed.
                we_next    = !wr_reg;
                state_next = NDAI_DATA;
            end
            NDAI_DATA: begin
                // R3: column half stable one cycle before the column strobe fall.
                cas_next = 1'b0;
                // R17: write strobe held low well past the lead before row rise.
                if (cnt_reg <= RC_C - ACCESS_C - CW'(1)) begin
                    // R10: sample after the row access time has elapsed.
                    rv_next  = !wr_reg;
                    rd_next  = wr_reg ? rd_reg : I_DATA_OUT;
                    ras_next = 1'b1;
                    cas_next = 1'b1;
                    state_next = NDAI_PRECH;
                end
            end
            NDAI_PRECH: begin
                // R16: write strobe rises one cycle after both strobes.
                we_next = 1'b1;
                // R14: leave once the cycle counter loaded at row fall has run out.
                if (cnt_reg == '0) begin
                    state_next = NDAI_IDLE;
                end
            end
            NDAI_CBR: begin
                // R20: row strobe falls after column strobe; device counter picks row.
                if (ras_reg && cnt_reg == '0) begin
                    ras_next = 1'b0;
                    cnt_next = ACCESS_C;
                end else if (!ras_reg && cnt_reg == '0) begin
                    ras_next = 1'b1;
                    cas_next = 1'b1;
                    cnt_next = PRECH_C;
                    init_next = O_INIT_DONE ? init_reg : init_reg + 4'h1;
                    state_next = NDAI_IDLE;
                end
            end
            default: begin
                state_next = NDAI_IDLE;
            end
        endcase
        if (tick) begin
            ref_pend_next = 1'b1;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg    <= NDAI_PAUSE;
            cnt_reg      <= POWERUP_C;
            init_reg     <= 4'h0;
            ref_pend_reg <= 1'b0;
            wr_reg       <= 1'b0;
            addr_reg     <= '0;
            wd_reg       <= 1'b0;
            ras_reg      <= 1'b1;
            cas_reg      <= 1'b1;
            we_reg       <= 1'b1;
            ma_reg       <= '0;
            rv_reg       <= 1'b0;
            rd_reg       <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            init_reg     <= init_next;
            ref_pend_reg <= ref_pend_next;
            wr_reg       <= wr_next;
            addr_reg     <= addr_next;
            wd_reg       <= wd_next;
            ras_reg      <= ras_next;
            cas_reg      <= cas_next;
            we_reg       <= we_next;
            ma_reg       <= ma_next;
            rv_reg       <= rv_next;
            rd_reg       <= rd_next;
        end
    end

    assign O_ROW_STROBE_B   = ras_reg;
    assign O_COL_STROBE_B   = cas_reg;
    assign O_WRITE_STROBE_B = we_reg;
    assign O_MUXED_ADDRESS  = ma_reg;
    // R5: data pin carries the data bit latched with every request, reads included; the device ignores it on reads.
    assign O_DATA_IN        = wd_reg;
    assign O_RDATA_VALID    = rv_reg;
    assign O_RDATA          = rd_reg;

    sequence s_row_fall;
        $fell(ras_reg) && cas_reg;
    endsequence

    chk_row_then_col: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R2
        s_row_fall |=> ##1 !ras_reg && $fell(cas_reg))
        else $error("Column strobe did not follow row strobe.");

    chk_col_addr_stable: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R3
        $fell(cas_reg) && !ras_reg |-> $stable(ma_reg))
        else $error("Address changed at column strobe fall.");

    chk_early_write: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R7
        $fell(cas_reg) && !ras_reg && wr_reg |-> !we_reg)
        else $error("Write strobe not low before column strobe.");

    chk_read_we_high: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R16
        !ras_reg && !wr_reg && state_reg != NDAI_CBR |-> we_reg)
        else $error("Write strobe low during a read.");

    chk_access_wait: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R10
        s_row_fall |-> !ras_reg [*3])
        else $error("Row strobe too short for access.");

    chk_cbr_order: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R20
        $fell(ras_reg) && !cas_reg |-> !$past(cas_reg))
        else $error("Refresh row fall without column precharge order.");

    chk_cycle_space: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R14
        $rose(ras_reg) |-> ras_reg [*2])
        else $error("Row precharge too short.");

    chk_powerup_high: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R18
        state_reg == NDAI_PAUSE |-> ras_reg && cas_reg)
        else $error("Strobes low during power-up pause.");

    chk_refresh_served: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R13
        O_INIT_DONE && $rose(ref_pend_reg) |-> ##[1:12] state_reg == NDAI_CBR)
        else $error("Refresh not started in time.");

    chk_write_lead: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B) // R17
        $rose(ras_reg) && wr_reg && state_reg == NDAI_PRECH |-> !$past(we_reg))
        else $error("Write strobe lead before row rise missed.");
endmodule

// ### verif/ndai_dram_model.sv
// Behavioural 1M x 1 strobe-driven RAM on the far side of the host controller.
// Assumes registered strobes and address; it counts every timing fault it sees.
`timescale 1ns/1ps
module ndai_dram_model
    import ndai_pkg::*;
(
    input  wire logic                i_row_strobe_b,
    input  wire logic                i_col_strobe_b,
    input  wire logic                i_write_strobe_b,
    input  wire logic [ROW_BITS-1:0] i_muxed_address,
    input  wire logic                i_data_in,
    input  wire logic                i_slow,
    output logic                     o_data_out,
    output int                       o_fault_cnt,
    output int                       o_refresh_cnt
);
    bit                  cell_mem [logic [ADDR_BITS-1:0]];
    logic [ROW_BITS-1:0] row_lat;
    logic [COL_BITS-1:0] col_lat;
    logic                rd_cyc   = 1'h0;
    logic                wr_cyc   = 1'h0;
    logic                last_out = 1'h0;
    logic                powered  = 1'h0;
    int                  init_cnt = 0;
    int                  n_ref    = 0;
    real                 k;
    realtime             t_rfall = -1000.0, t_rrise = 0.0, t_cfall = -1000.0;
    realtime             t_crise = -1000.0, t_wfall = -1000.0, t_addr = 0.0;
    realtime             t_ref0 = 0.0, rd_at = 0.0;

    initial begin
        o_fault_cnt = 0;
        o_refresh_cnt = 0;
    end

    always @(i_muxed_address) t_addr = $realtime;
    always @(posedge i_col_strobe_b) t_crise = $realtime;

    always @(negedge i_row_strobe_b) begin
        // power-up pause and eight counter refreshes.
        if ($realtime - t_rrise >= 200000.0) begin
            powered = 1'h1;
            init_cnt = 0;
            n_ref = 0;
        end else if (!powered) o_fault_cnt++;
        if ($realtime - t_rfall < 140.0) o_fault_cnt++;
        t_rfall = $realtime;
        rd_cyc = 1'h0;
        wr_cyc = 1'h0;
        if (!i_col_strobe_b) begin
            // counter refresh with precharge and average rate.
            if (t_cfall - t_crise < 20.0) o_fault_cnt++;
            if (n_ref == 0) t_ref0 = $realtime;
            else if ($realtime - t_ref0 > n_ref * 16015.625 + 350.0) o_fault_cnt++;
            n_ref++;
            init_cnt++;
            o_refresh_cnt++;
        end else begin
            // row latch on the falling row strobe.
            if (t_addr >= $realtime) o_fault_cnt++;
            if (init_cnt < 8) o_fault_cnt++;
            row_lat = i_muxed_address;
        end
    end

    always @(negedge i_col_strobe_b) begin
        t_cfall = $realtime;
        if (!i_row_strobe_b) begin
            // column latch on the falling column strobe.
            if (t_addr >= $realtime) o_fault_cnt++;
            col_lat = i_muxed_address;
            // early write takes data here, a read ignores it.
            if (!i_write_strobe_b) begin
                cell_mem[{row_lat, col_lat}] = i_data_in;
                wr_cyc = 1'h1;
            end else begin
                k = i_slow ? 1.0 : 0.5;
                rd_cyc = 1'h1;
                // access from row strobe, column strobe or address.
                rd_at = t_rfall + 70.0 * k;
                if (t_cfall + 20.0 * k > rd_at) rd_at = t_cfall + 20.0 * k;
                if (t_addr + 35.0 * k > rd_at) rd_at = t_addr + 35.0 * k;
            end
        end
    end

    always @(negedge i_write_strobe_b) begin
        t_wfall = $realtime;
        // delayed write takes data on the write strobe.
        if (!i_col_strobe_b && !i_row_strobe_b && rd_cyc) begin
            cell_mem[{row_lat, col_lat}] = i_data_in;
            wr_cyc = 1'h1;
        end
    end

    // write lead before the row strobe rises.
    always @(posedge i_row_strobe_b) begin
        if (wr_cyc && $realtime - t_wfall < 15.0) o_fault_cnt++;
        t_rrise = $realtime;
    end

    // read command hold to the rising strobes.
    always @(posedge i_row_strobe_b or posedge i_col_strobe_b) begin
        if (rd_cyc && !wr_cyc && !i_write_strobe_b) o_fault_cnt++;
    end

    // output floats, seen as the inverse of the last bit.
    always #1 begin
        if (!i_col_strobe_b && !i_row_strobe_b && rd_cyc && $realtime >= rd_at) begin
            o_data_out = cell_mem[{row_lat, col_lat}];
            last_out = o_data_out;
        end else o_data_out = ~last_out;
    end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the host controller of the strobe-driven RAM.
// Assumes the behavioural RAM model answers on the strobe side.
`timescale 1ns/1ps
module testbench
    import ndai_pkg::*;
;
    typedef struct packed {logic wr; logic [ADDR_BITS-1:0] addr; logic wd; logic exp;} ndai_row_s;
    localparam ndai_row_s ROWS [10] = '{
        '{1'h1, 20'h00000, 1'h1, 1'h0}, '{1'h1, 20'hfffff, 1'h0, 1'h0},
        '{1'h1, 20'h003ff, 1'h1, 1'h0}, '{1'h1, 20'hffc00, 1'h1, 1'h0},
        '{1'h0, 20'h00000, 1'h0, 1'h1}, '{1'h0, 20'hfffff, 1'h1, 1'h0},
        '{1'h0, 20'h003ff, 1'h0, 1'h1}, '{1'h0, 20'hffc00, 1'h0, 1'h1},
        '{1'h1, 20'h00000, 1'h0, 1'h0}, '{1'h0, 20'h00000, 1'h1, 1'h0}};
    logic                 ref_clk = 1'h0, rst_b = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic                 req_wdata = 1'h0, slow = 1'h0;
    logic [ADDR_BITS-1:0] req_addr = 20'h0, taken_addr = 20'h0;
    logic                 taken_wr = 1'h0, taken_wd = 1'h0;
    logic                 req_ready, rdata_valid, rdata, init_done, row_b, col_b, we_b, din, dout;
    logic [ROW_BITS-1:0]  mux_addr, seen_row;
    int                   n_mismatch = 0, checks = 0, faults, refreshes;

    always #25 ref_clk = ~ref_clk;

    ndai_host ndai_host_inst (.I_REF_CLK(ref_clk), .I_RST_B(rst_b), .I_REQ_VALID(req_valid),
        .I_REQ_WRITE(req_write), .I_REQ_ADDR(req_addr), .I_REQ_WDATA(req_wdata),
        .O_REQ_READY(req_ready), .O_RDATA_VALID(rdata_valid), .O_RDATA(rdata),
        .O_INIT_DONE(init_done), .O_ROW_STROBE_B(row_b), .O_COL_STROBE_B(col_b),
        .O_WRITE_STROBE_B(we_b), .O_MUXED_ADDRESS(mux_addr), .O_DATA_IN(din), .I_DATA_OUT(dout));
    ndai_dram_model ndai_dram_model_inst (.i_row_strobe_b(row_b), .i_col_strobe_b(col_b),
        .i_write_strobe_b(we_b), .i_muxed_address(mux_addr), .i_data_in(din), .i_slow(slow),
        .o_data_out(dout), .o_fault_cnt(faults), .o_refresh_cnt(refreshes));

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_vec(input string what, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_num(input string what, input int exp, input int got);
        checks++;
        if (got != exp) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(negedge row_b) if (col_b) seen_row = mux_addr;
    always @(negedge col_b) if (!row_b) begin
        cmp_vec("row half", taken_addr[19:10], seen_row);
        cmp_vec("column half", taken_addr[9:0], mux_addr);
        cmp_bit("write strobe at column", ~taken_wr, we_b);
        if (taken_wr) cmp_bit("data in", taken_wd, din);
    end

    task automatic wait_init();
        int c;
        int early;
        c = 0;
        early = 0;
        req_valid = 1'h1;
        while (init_done !== 1'h1 && c < 6000) begin
            @(negedge ref_clk);
            c++;
            if (req_ready !== 1'h0 && init_done !== 1'h1) early++;
        end
        req_valid = 1'h0;
        cmp_bit("pause length", 1'h1, c >= POWERUP_CYC);
        cmp_num("ready during init", 0, early);
    endtask

    task automatic req(input ndai_row_s r);
        int n;
        req_valid = 1'h1;
        req_write = r.wr;
        req_addr = r.addr;
        req_wdata = r.wd;
        n = 0;
        #20;
        while (req_ready !== 1'h1 && n < 40) begin
            @(negedge ref_clk);
            #20;
            n++;
        end
        cmp_bit("request taken", 1'h1, req_ready);
        taken_addr = r.addr;
        taken_wr = r.wr;
        taken_wd = r.wd;
        @(negedge ref_clk);
        if (r.wr === 1'h0) begin
            req_valid = 1'h0;
            n = 0;
            while (rdata_valid !== 1'h1 && n < 12) begin
                @(negedge ref_clk);
                n++;
            end
            cmp_bit("read valid", 1'h1, rdata_valid);
            cmp_bit("read data", r.exp, rdata);
        end
    endtask

    initial begin
        #(30000 * 50);
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        cmp_vec("strobes in reset", 10'h7, {7'h0, row_b, col_b, we_b});
        cmp_bit("ready in reset", 1'h0, req_ready);
        @(negedge ref_clk);
        rst_b = 1'h1;
        @(negedge ref_clk);
        wait_init();
        for (int i = 0; i < 10; i++) begin
            slow = (i >= 5);
            req(ROWS[i]);
        end
        @(negedge ref_clk);
        req_valid = 1'h1;
        req_write = 1'h0;
        req_addr = 20'h00000;
        repeat (3) @(negedge ref_clk);
        rst_b = 1'h0;
        @(negedge ref_clk);
        req_valid = 1'h0;
        cmp_vec("strobes after abort", 10'h7, {7'h0, row_b, col_b, we_b});
        cmp_bit("no answer after abort", 1'h0, rdata_valid);
        repeat (4) @(negedge ref_clk);
        rst_b = 1'h1;
        @(negedge ref_clk);
        wait_init();
        req(ndai_row_s'{1'h0, 20'h003ff, 1'h0, 1'h1});
        @(negedge ref_clk);
        cmp_num("device timing faults", 0, faults);
        cmp_bit("refreshes issued", 1'h1, refreshes >= 16);
        conclude();
    end
endmodule
